// ### hw/uesd_pkg.sv
// package: register map, field layout and types of the endpoint status and dma control block
package uesd_pkg;
  localparam int          NUM_EP          = 4;
  localparam int          EP_W            = 2;
  localparam int          NUM_DMA_CH      = 3;
  localparam logic [7:0]  A_SEND          = 8'h00;
  localparam logic [7:0]  A_TOGCLR        = 8'h04;
  localparam logic [7:0]  A_DMACH         = 8'h08;
  localparam logic [7:0]  A_DMAEN         = 8'h0C;
  localparam logic [7:0]  A_DMADIS        = 8'h10;
  localparam logic [7:0]  A_SEL           = 8'h14;
  localparam logic [7:0]  A_STATUS        = 8'h18;
  localparam logic [7:0]  A_STCLR         = 8'h1C;
  localparam logic [7:0]  A_FIFOADDR      = 8'h20;
  localparam logic [7:0]  A_CTRL          = 8'h24;
  localparam logic [7:0]  A_BUSY          = 8'h28;
  localparam logic [7:0]  A_IRQ_ST        = 8'h2C;
  localparam logic [7:0]  A_IRQ_EN        = 8'h30;
  localparam logic [7:0]  A_IRQ_CLR       = 8'h34;
  localparam logic [7:0]  A_DMASTAT       = 8'h38;
  localparam logic [31:0] FIFO_BASE       = 32'h4005_0020;
  localparam logic [31:0] FIFO_STRIDE     = 32'h0000_0004;
  localparam logic [31:0] RD_UNMAPPED     = 32'h0000_0000;
  localparam logic [7:0]  MAXPKT_RESET    = 8'h40;
  // direction selector values
  localparam logic [1:0]  DIR_HOST_OUT    = 2'd0;
  localparam logic [1:0]  DIR_HOST_IN     = 2'd1;
  localparam logic [1:0]  DIR_DEV_OUT     = 2'd2;
  localparam logic [1:0]  DIR_DEV_IN      = 2'd3;
  // status word bit positions: host 14..31, device 0..13
  localparam int ST_W = 32;
  typedef enum logic [4:0] {
    TXN_HOST_OUT    = 5'b00001,
    TXN_DEV_IN      = 5'b00010,
    TXN_CTRL_FINAL  = 5'b00100,
    TXN_CTRL_SETUP  = 5'b01000,
    TXN_CTRL_STATUS = 5'b10000
  } uesd_txn_t;
  typedef struct packed {
    logic [7:0] h_rx;   // pid, noresp, stall, crc, nak, err, full, pktrdy
    logic [5:0] h_tx;   // nak, noresp, stall, err, nonempty(lvl), pending(lvl)
    logic [3:0] h_ctrl; // nak, noresp, rxstall, rxpkt
    logic [4:0] d_rx;   // stall, crc, dropped, full(lvl), pktrdy
    logic [4:0] d_tx;   // split, stall, nodata, nonempty(lvl), pending(lvl)
    logic [3:0] d_ctrl; // early end, stall, txpend(lvl), rxpkt
  } uesd_status_t;
  // one-cycle events reported by the usb engine for one endpoint
  typedef struct packed {
    logic [EP_W-1:0] ep;
    logic            valid;
    uesd_status_t    flags;
  } uesd_event_t;
  localparam logic [31:0] LEVEL_MASK = 32'h0003_0000 >> 16 << 14 | 32'h0000_0000;
  localparam int IRQ_SEND_DONE = 0;
  localparam int IRQ_STATUS    = 1;
  localparam int IRQ_REFUSED   = 2;
  localparam int IRQ_W         = 3;
endpackage : uesd_pkg

// ### hw/uesd_top.sv
// module: endpoint send, toggle, dma routing and sticky status for a dual-role usb controller
`timescale 1ns/1ps
module uesd_top
  import uesd_pkg::*;
#(
  parameter int NEP = uesd_pkg::NUM_EP
) (
  input  wire logic                   clk,              // 50 mhz controller clock
  input  wire logic                   rstn,             // async active-low reset
  input  wire logic [7:0]             avs_address,      // byte address
  input  wire logic                   avs_read,         // read request
  input  wire logic                   avs_write,        // write request
  input  wire logic [31:0]            avs_writedata,    // write data
  input  wire logic [3:0]             avs_byteenable,   // byte lanes
  output logic      [31:0]            avs_readdata,     // read data
  output logic                        avs_waitrequest,  // stall
  input  wire logic                   host_role,        // 1 host, 0 device
  input  wire uesd_pkg::uesd_event_t  bus_event,        // sticky event pulses from engine
  input  wire logic [NEP-1:0]         tx_done,          // engine finished transmission per ep
  input  wire logic [NEP-1:0]         fifo_wr,          // one byte written into ep buffer
  input  wire logic [NEP-1:0]         rx_dma_req_ep,    // engine dma request, receive, per ep
  input  wire logic [NEP-1:0]         tx_dma_req_ep,    // engine dma request, transmit, per ep
  output logic                        tx_start,         // start pulse to engine
  output logic      [uesd_pkg::EP_W-1:0] tx_start_ep,   // endpoint of start
  output uesd_pkg::uesd_txn_t         tx_start_type,    // transaction type of start
  output logic      [NEP-1:0]         toggle_clr_tx,    // clear tx data toggle pulse
  output logic      [NEP-1:0]         toggle_clr_rx,    // clear rx data toggle pulse
  output logic      [2:0]             rx_dma_req,       // receive dma request channels
  output logic      [2:0]             tx_dma_req,       // transmit dma request channels
  output logic                        irq               // level interrupt
);
  import uesd_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode: single-cycle wait then answer, every access takes two cycles
  logic        ack_r;
  logic        wr_go, rd_go;
  logic [31:0] wd;
  assign wr_go = avs_write & ~ack_r;
  assign rd_go = avs_read & ~ack_r;
  always_comb begin
    for (int b = 0; b < 4; b++) wd[b*8 +: 8] = avs_byteenable[b] ? avs_writedata[b*8 +: 8] : 8'h00;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) ack_r <= 1'b0;
    else ack_r <= (avs_read | avs_write) & ~ack_r;
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  logic [EP_W-1:0] sel_r;                  // endpoint selected for status / address reads
  logic [NEP-1:0]  auto_r;                 // auto transmit per ep
  logic [7:0]      maxpkt_r;
  logic [NEP-1:0]  dma_rx_en_r, dma_tx_en_r;
  logic [NEP-1:0]  dma_mode_rx_r, dma_mode_tx_r;
  logic [EP_W-1:0] rx_map_r [NUM_DMA_CH];
  logic [EP_W-1:0] tx_map_r [NUM_DMA_CH];
  logic [NEP-1:0]  busy_r;
  logic [7:0]      fill_r [NEP];
  uesd_status_t    st_r [NEP];
  logic [IRQ_W-1:0] irq_st_r, irq_en_r;

  wire w_send   = wr_go && avs_address == A_SEND;
  wire w_togclr = wr_go && avs_address == A_TOGCLR;
  wire w_dmach  = wr_go && avs_address == A_DMACH;
  wire w_dmaen  = wr_go && avs_address == A_DMAEN;
  wire w_dmadis = wr_go && avs_address == A_DMADIS;
  wire w_stclr  = wr_go && avs_address == A_STCLR;
  wire [EP_W-1:0] cmd_ep = wd[EP_W-1:0];
  wire [1:0]      cmd_dir = wd[9:8];
  wire            cmd_in  = (cmd_dir == DIR_HOST_IN) || (cmd_dir == DIR_DEV_IN);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_r    <= '0;
      auto_r   <= '0;
      maxpkt_r <= MAXPKT_RESET;
    end else if (wr_go && avs_address == A_SEL) begin
      sel_r <= wd[EP_W-1:0];
    end else if (wr_go && avs_address == A_CTRL) begin
      auto_r   <= wd[NEP-1:0];
      maxpkt_r <= wd[15:8];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // send requests: software or auto, refused while busy
  logic     sw_ok, refused;
  uesd_txn_t req_type;
  logic [NEP-1:0] auto_go;
  always_comb begin
    unique case (wd[12:8])
      5'b00001: req_type = TXN_HOST_OUT;
      5'b00010: req_type = TXN_DEV_IN;
      5'b00100: req_type = TXN_CTRL_FINAL;
      5'b01000: req_type = TXN_CTRL_SETUP;
      default:  req_type = TXN_CTRL_STATUS;
    endcase
  end
  assign sw_ok   = w_send && !busy_r[cmd_ep] && !auto_r[cmd_ep];
  assign refused = w_send && (busy_r[cmd_ep] || auto_r[cmd_ep]);

  genvar e;
  generate
    for (e = 0; e < NEP; e++) begin : g_ep
      assign auto_go[e] = auto_r[e] && !busy_r[e] && fifo_wr[e] && (fill_r[e] + 8'd1 >= maxpkt_r);
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) fill_r[e] <= '0;
        else if (auto_go[e]) fill_r[e] <= '0;
        else if (fifo_wr[e] && fill_r[e] != 8'hFF) fill_r[e] <= fill_r[e] + 8'd1;
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) busy_r[e] <= 1'b0;
        else if ((sw_ok && cmd_ep == EP_W'(e)) || auto_go[e]) busy_r[e] <= 1'b1;
        else if (tx_done[e]) busy_r[e] <= 1'b0;
      end
      // sticky flags: set wins over a clear in the same cycle
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) st_r[e] <= '0;
        else st_r[e] <= (st_r[e] & ~((w_stclr && cmd_ep == EP_W'(e)) ? uesd_status_t'(avs_writedata) : '0))
                      | ((bus_event.valid && bus_event.ep == EP_W'(e)) ? bus_event.flags : '0);
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_start      <= 1'b0;
      tx_start_ep   <= '0;
      tx_start_type <= TXN_HOST_OUT;
    end else begin
      tx_start <= sw_ok | (|auto_go);
      if (sw_ok) begin
        tx_start_ep   <= cmd_ep;
        tx_start_type <= req_type;
      end else begin
        for (int i = 0; i < NEP; i++) begin
          if (auto_go[i]) begin
            tx_start_ep   <= EP_W'(i);
            tx_start_type <= host_role ? TXN_HOST_OUT : TXN_DEV_IN;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // toggle clears, not for endpoint zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      toggle_clr_tx <= '0;
      toggle_clr_rx <= '0;
    end else begin
      toggle_clr_tx <= '0;
      toggle_clr_rx <= '0;
      if (w_togclr && cmd_ep != '0) begin
        if (cmd_dir == DIR_HOST_OUT || cmd_dir == DIR_DEV_IN) toggle_clr_tx[cmd_ep] <= 1'b1;
        else toggle_clr_rx[cmd_ep] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // dma enable / disable and channel map
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dma_rx_en_r   <= '0;
      dma_tx_en_r   <= '0;
      dma_mode_rx_r <= '0;
      dma_mode_tx_r <= '0;
    end else if (w_dmaen) begin
      if (cmd_dir == DIR_DEV_IN) begin
        dma_tx_en_r[cmd_ep]   <= 1'b1;
        dma_mode_tx_r[cmd_ep] <= wd[16];
      end else begin
        dma_rx_en_r[cmd_ep]   <= 1'b1;
        dma_mode_rx_r[cmd_ep] <= wd[16];
      end
    end else if (w_dmadis) begin
      if (cmd_dir == DIR_DEV_IN) dma_tx_en_r[cmd_ep] <= 1'b0;
      else dma_rx_en_r[cmd_ep] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < NUM_DMA_CH; c++) begin
        rx_map_r[c] <= EP_W'(c + 1);
        tx_map_r[c] <= EP_W'(c + 1);
      end
    end else if (w_dmach && cmd_ep != '0 && wd[17:16] < 2'd3) begin
      if (wd[20]) tx_map_r[wd[17:16]] <= cmd_ep;
      else rx_map_r[wd[17:16]] <= cmd_ep;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_dma_req <= '0;
      tx_dma_req <= '0;
    end else begin
      for (int c = 0; c < NUM_DMA_CH; c++) begin
        rx_dma_req[c] <= rx_dma_req_ep[rx_map_r[c]] & dma_rx_en_r[rx_map_r[c]];
        tx_dma_req[c] <= tx_dma_req_ep[tx_map_r[c]] & dma_tx_en_r[tx_map_r[c]];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // interrupts: status events only raised for endpoints with neither direction under dma
  logic [IRQ_W-1:0] irq_ev;
  wire ev_dma = bus_event.valid && (dma_rx_en_r[bus_event.ep] || dma_tx_en_r[bus_event.ep]);
  assign irq_ev[IRQ_SEND_DONE] = |(tx_done & busy_r);
  assign irq_ev[IRQ_STATUS]    = bus_event.valid && (|bus_event.flags) && !ev_dma;
  assign irq_ev[IRQ_REFUSED]   = refused;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_st_r <= '0;
      irq_en_r <= '0;
      irq      <= 1'b0;
    end else begin
      irq_st_r <= (irq_st_r & ~((wr_go && avs_address == A_IRQ_CLR) ? wd[IRQ_W-1:0] : '0)) | irq_ev;
      if (wr_go && avs_address == A_IRQ_EN) irq_en_r <= wd[IRQ_W-1:0];
      irq <= |(irq_st_r & irq_en_r);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] rd;
  always_comb begin
    unique case (avs_address)
      A_STATUS:   rd = 32'(st_r[sel_r]);
      A_FIFOADDR: rd = FIFO_BASE + FIFO_STRIDE * 32'(sel_r);
      A_CTRL:     rd = {16'h0000, maxpkt_r, 8'(auto_r)};
      A_SEL:      rd = 32'(sel_r);
      A_BUSY:     rd = 32'(busy_r);
      A_IRQ_ST:   rd = 32'(irq_st_r);
      A_IRQ_EN:   rd = 32'(irq_en_r);
      A_DMASTAT:  rd = {8'h00, 8'(dma_mode_tx_r), 8'(dma_mode_rx_r), 4'(dma_tx_en_r), 4'(dma_rx_en_r)};
      default:    rd = RD_UNMAPPED;
    endcase
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) avs_readdata <= '0;
    else if (rd_go) avs_readdata <= rd;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) avs_waitrequest <= 1'b1;
    else avs_waitrequest <= ~((avs_read | avs_write) & ~ack_r);
  end
endmodule : uesd_top

// ### dv/uesd_sva.sv
// checker: bus handshake, start and toggle pulse properties
`timescale 1ns/1ps
module uesd_sva
  import uesd_pkg::*;
#(
  parameter int NEP = uesd_pkg::NUM_EP
) (
  input wire logic                      clk,             // clock
  input wire logic                      rstn,            // reset
  input wire logic                      avs_read,        // read
  input wire logic                      avs_write,       // write
  input wire logic [31:0]               avs_readdata,    // read data
  input wire logic                      avs_waitrequest, // stall
  input wire logic                      tx_start,        // start pulse
  input wire logic [uesd_pkg::EP_W-1:0] tx_start_ep,     // start ep
  input wire uesd_pkg::uesd_txn_t       tx_start_type,   // start type
  input wire logic [NEP-1:0]            toggle_clr_tx,   // tx clear
  input wire logic [NEP-1:0]            toggle_clr_rx,   // rx clear
  input wire logic [NEP-1:0]            rx_dma_req_ep,   // engine rx req
  input wire logic [2:0]                rx_dma_req       // rx channels
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////
  sequence s_req_held;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_start_ends;
    ##1 !tx_start;
  endsequence
  a_bus_answer: assert property (s_req_held |=> !avs_waitrequest) else $error("request not answered");
  a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  a_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("answer without request");
  a_rdata_hold: assert property (!avs_read |=> $stable(avs_readdata)) else $error("read data moved");
  a_start_pulse: assert property (tx_start |-> s_start_ends) else $error("start longer than one cycle");
  a_type_onehot: assert property ($onehot(tx_start_type)) else $error("start type not one-hot");
  a_type_hold: assert property (!tx_start |-> $stable(tx_start_type) && $stable(tx_start_ep))
    else $error("start type or ep moved");
  a_tog_ep0: assert property (!toggle_clr_tx[0] && !toggle_clr_rx[0]) else $error("toggle clear on ep0");
  a_tog_pulse: assert property ((toggle_clr_tx | toggle_clr_rx) != 0 |=> (toggle_clr_tx | toggle_clr_rx) == 0)
    else $error("toggle clear longer than one cycle");
  a_dma_quiet: assert property (rx_dma_req_ep == 0 [*3] |-> rx_dma_req == 3'b000)
    else $error("dma request without engine request");
endmodule : uesd_sva
bind uesd_top uesd_sva #(.NEP(NEP)) u_sva (.clk, .rstn, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .tx_start, .tx_start_ep, .tx_start_type, .toggle_clr_tx, .toggle_clr_rx, .rx_dma_req_ep, .rx_dma_req);

// ### dv/uesd_engine_model.sv
// partner model: usb engine that ends each transfer after a settable latency
`timescale 1ns/1ps
module uesd_engine_model
  import uesd_pkg::*;
#(
  parameter int NEP = uesd_pkg::NUM_EP
) (
  input  wire logic                      clk,         // clock
  input  wire logic                      rstn,        // reset
  input  wire logic                      tx_start,    // start pulse
  input  wire logic [uesd_pkg::EP_W-1:0] tx_start_ep, // ep to send
  input  wire logic [7:0]                lat,         // transfer length
  output logic      [NEP-1:0]            tx_done      // done pulse
);
  logic [7:0]      left_r;
  logic [EP_W-1:0] ep_r;
  // one transfer at a time: the block refuses software starts to an endpoint that is busy or set to auto transmit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      left_r  <= 8'h00;
      ep_r    <= '0;
      tx_done <= '0;
    end else begin
      tx_done <= '0;
      if (tx_start) begin
        left_r <= lat;
        ep_r   <= tx_start_ep;
      end else if (left_r != 8'h00) begin
        left_r <= left_r - 8'h01;
        if (left_r == 8'h01) tx_done[ep_r] <= 1'b1;
      end
    end
  end
endmodule : uesd_engine_model

// ### dv/uesd_top_test.sv
// testbench: endpoint send, toggle, status, auto transmit and dma routing
`timescale 1ns/1ps
module uesd_top_test;
  import uesd_pkg::*;
  logic        clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0, host_role = 1'b1, avs_waitrequest, tx_start, irq;
  logic [7:0]  avs_address = 8'h00, lat = 8'd20;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
  logic [3:0]  avs_byteenable = 4'hF, tx_done, fifo_wr = 4'h0, rx_dma_req_ep = 4'h0, tx_dma_req_ep = 4'h0;
  logic [3:0]  toggle_clr_tx, toggle_clr_rx, tg_tx = 4'h0, tg_rx = 4'h0;
  logic [2:0]  rx_dma_req, tx_dma_req;
  logic [1:0]  tx_start_ep, s_ep;
  uesd_txn_t   tx_start_type, s_ty;
  uesd_event_t bus_event = '0;
  int          fail_count = 0, check_count = 0, n_start = 0;
  uesd_top #(.NEP(NUM_EP)) u_dut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .host_role, .bus_event, .tx_done, .fifo_wr, .rx_dma_req_ep, .tx_dma_req_ep,
    .tx_start, .tx_start_ep, .tx_start_type, .toggle_clr_tx, .toggle_clr_rx, .rx_dma_req, .tx_dma_req, .irq);
  uesd_engine_model #(.NEP(NUM_EP)) u_eng (.clk, .rstn, .tx_start, .tx_start_ep, .lat, .tx_done);
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (tx_start === 1'b1) begin
      n_start++;
      s_ep = tx_start_ep;
      s_ty = tx_start_type;
    end
    tg_tx = tg_tx | toggle_clr_tx;
    tg_rx = tg_rx | toggle_clr_rx;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  // one avalon access; an idle edge follows so strobes never toggle twice in one step
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : acc
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic ev(input logic [1:0] e, input logic [31:0] f);
    @(posedge clk);
    bus_event <= {e, 1'b1, f};
    @(posedge clk);
    bus_event <= '0;
    cyc(3);
  endtask : ev
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////
  task automatic t_regs;
    acc(0, A_CTRL, 0);
    chk(rdv, 32'h0000_4000, "ctrl reset");
    acc(1, 8'h3C, 32'hFFFF_FFFF);
    acc(0, 8'h3C, 0);
    chk(rdv, RD_UNMAPPED, "unmapped");
    for (int e = 0; e < NUM_EP; e++) begin
      acc(1, A_SEL, 32'(e));
      acc(0, A_FIFOADDR, 0);
      chk(rdv, FIFO_BASE + FIFO_STRIDE * 32'(e), "fifo addr");
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_send;
    uesd_txn_t ty[5] = '{TXN_HOST_OUT, TXN_DEV_IN, TXN_CTRL_FINAL, TXN_CTRL_SETUP, TXN_CTRL_STATUS};
    int n0;
    acc(1, A_IRQ_EN, 32'h0000_0007);
    foreach (ty[i]) begin
      n0 = n_start;
      acc(1, A_SEND, {19'h0, ty[i], 6'h0, 2'd1});
      chk(n_start - n0, 1, "start");
      chk({s_ty, s_ep}, {ty[i], 2'd1}, "start type");
      acc(0, A_BUSY, 0);
      chk(rdv[1], 1'b1, "busy");
      acc(1, A_SEND, {19'h0, ty[i], 6'h0, 2'd1});
      chk(n_start - n0, 1, "busy refused");
      acc(0, A_IRQ_ST, 0);
      chk({irq, rdv[2:0]}, 4'b1100, "irq refused");
      cyc(25);
      acc(0, A_BUSY, 0);
      chk(rdv[1], 1'b0, "idle");
      acc(1, A_IRQ_CLR, 32'h0000_0007);
      chk(irq, 1'b0, "irq clear");
    end
    $display("test send done");
  endtask : t_send
  task automatic t_toggle;
    logic [3:0] etx = 4'b1001; // host out and device in clear the transmit toggle
    for (int d = 0; d < 4; d++) begin
      for (int e = 0; e < 2; e++) begin
        tg_tx = 4'h0;
        tg_rx = 4'h0;
        acc(1, A_TOGCLR, {22'h0, 2'(d), 6'h0, 2'(e)});
        chk({tg_tx, tg_rx}, e == 0 ? 8'h00 : (etx[d] ? 8'h20 : 8'h02), "toggle");
      end
    end
    $display("test toggle done");
  endtask : t_toggle
  task automatic t_status;
    logic [31:0] fl[2] = '{32'h8080_4000, 32'h0000_2040};
    acc(1, A_SEL, 32'h0000_0002);
    for (int r = 0; r < 2; r++) begin
      host_role <= (r == 0);
      ev(2'd2, fl[r]);
      cyc(20);
      acc(0, A_STATUS, 0);
      chk(rdv, fl[r], "flags sticky");
      chk(irq, 1'b1, "status irq");
      acc(1, A_STCLR, fl[r] | 32'h0000_0002);
      acc(0, A_STATUS, 0);
      chk(rdv, 32'h0, "flags cleared");
      acc(1, A_IRQ_CLR, 32'h0000_0002);
    end
    $display("test status done");
  endtask : t_status
  task automatic t_auto;
    int n0;
    lat <= 8'd2;
    acc(1, A_CTRL, 32'h0000_0408);
    n0 = n_start;
    for (int b = 1; b <= 4; b++) begin
      fifo_wr <= 4'b1000;
      @(posedge clk);
      fifo_wr <= 4'b0000;
      cyc(3);
      chk(n_start - n0, 32'(b == 4), "auto start");
    end
    chk(s_ep, 2'd3, "auto ep");
    acc(1, A_SEND, 32'h0000_0203);
    chk(n_start - n0, 1, "auto refused");
    $display("test auto done");
  endtask : t_auto
  task automatic t_dma;
    // tx channel 0 moves off its reset endpoint so the remap is visible
    acc(1, A_DMACH, 32'h0010_0002);
    acc(1, A_DMACH, 32'h0000_0000);
    acc(1, A_DMAEN, 32'h0001_0302);
    acc(1, A_DMAEN, 32'h0000_0101);
    acc(0, A_DMASTAT, 0);
    chk(rdv, 32'h0004_0042, "dma mode latched");
    rx_dma_req_ep <= 4'b0011;
    tx_dma_req_ep <= 4'b0101;
    cyc(4);
    chk({rx_dma_req, tx_dma_req}, 6'b001_011, "dma map");
    ev(2'd2, 32'h0000_0040);
    acc(0, A_IRQ_ST, 0);
    chk(rdv[1], 1'b0, "dma ep quiet");
    acc(1, A_DMADIS, 32'h00F0_0302);
    cyc(4);
    chk(tx_dma_req, 3'b000, "dma off");
    ev(2'd2, 32'h0000_0040);
    acc(0, A_IRQ_ST, 0);
    chk(rdv[1], 1'b1, "irq back");
    $display("test dma done");
  endtask : t_dma
  ////////////////////////////////////////
  initial begin
    #400000;
    fail_count++;
    $display("mismatch at %0t: watchdog", $time);
    report_and_stop();
  end
  initial begin
    cyc(20);
    rstn <= 1'b1;
    @(posedge clk);
    t_regs();
    t_send();
    t_toggle();
    t_status();
    t_auto();
    t_dma();
    report_and_stop();
  end
endmodule : uesd_top_test
